// file: inc/drc_defs.svh
/*
 * offsets, field positions, opcodes and sector constants of the disk
 * read command executor. assumes inclusion by bare name.
 */
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH

`define DRC_OFF_DATA 4'h0
`define DRC_OFF_ERROR 4'h1
`define DRC_OFF_FEATURE 4'h1
`define DRC_OFF_COUNT 4'h2
`define DRC_OFF_SECTOR 4'h3
`define DRC_OFF_CYL_LO 4'h4
`define DRC_OFF_CYL_HI 4'h5
`define DRC_OFF_DEVHEAD 4'h6
`define DRC_OFF_STATUS 4'h7
`define DRC_OFF_COMMAND 4'h7
`define DRC_OFF_CONTROL 4'h8

`define DRC_OP_NATIVE_MAX 8'h27
`define DRC_OP_READ_RETRY 8'h20
`define DRC_OP_READ_NORETRY 8'h21

`define DRC_DH_LBA_BIT 6
`define DRC_CTL_HOB_BIT 7

`define DRC_ERR_UNC_BIT 6
`define DRC_ERR_IDN_BIT 4
`define DRC_ERR_ABT_BIT 2

`define DRC_ST_BSY_BIT 7
`define DRC_ST_RDY_BIT 6
`define DRC_ST_DSC_BIT 4
`define DRC_ST_DRQ_BIT 3
`define DRC_ST_ERR_BIT 0

`define DRC_WORDS_PER_SECTOR 9'h100
`define DRC_COUNT_ZERO_SECTORS 9'h100

`endif

// file: inc/drc_pkg.sv
/*
 * types shared by the disk read command executor.
 * assumes drc_defs.svh is on the include path.
 */
package drc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_XFER = 3'b010,
		ST_DONE = 3'b011
	} drc_state_type;

	typedef struct packed {
		logic [7:0] sector;
		logic [7:0] cyl_lo;
		logic [7:0] cyl_hi;
		logic [3:0] head;
	} drc_addr_type;

	typedef struct packed {
		logic req;
		logic [27:0] lba;
	} drc_media_req_type;

	typedef struct packed {
		logic valid;
		logic fail;
		logic not_found;
		logic [15:0] word;
	} drc_media_rsp_type;
endpackage : drc_pkg

// file: verilog/drc_byte_sel.sv
/*
 * picks the low or high byte of a 48-bit address for one task file
 * register. assumes a plain combinational context.
 */
`timescale 1ns/1ps
module drc_byte_sel (
	input wire logic [47:0] addr,
	input wire logic high_byte_select,
	input wire logic [1:0] lane,
	output logic [7:0] byte_out
);
	// lane 0 sector, 1 cylinder low, 2 cylinder high
	always_comb begin
		byte_out = high_byte_select ? addr[8*lane+24 +: 8] : addr[8*lane +: 8];
	end
endmodule : drc_byte_sel

// file: verilog/drc_exec.sv
/*
 * device side executor for the native max address ext and read sectors
 * commands. assumes a host that writes the command block registers over
 * a plain strobe port, and a media engine that returns sector words.
 */
`timescale 1ns/1ps
`include "drc_defs.svh"
// Contract
// - native max ext command returns true top address, ignoring capacity limits
// - result readable by byte, high byte select picks upper three bytes
// - read sectors fetches sectors from media and delivers them to host
// - both read opcodes accepted, retry bit ignored
// - sector count gives sectors to read, zero means 256
// - sector data moves through data register sixteen bits at a time
// - uncorrectable error stops the read at the failing sector
// - completion leaves count of sectors not transferred
// - chs mode reports sector and cylinder of last transferred sector
// - lba mode reports current address low three bytes
// - head nibble reports last head or address bits 24 to 27
module drc_exec (
	sys_clk,
	sys_rst,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	native_max,
	media_req,
	media_rsp,
	busy
);
	import drc_pkg::*;
	parameter logic [15:0] SECTORS_PER_TRACK = 16'h003F;
	parameter logic [3:0] HEADS = 4'hF;
	input wire logic sys_clk;
	input wire logic sys_rst;
	input wire logic [3:0] reg_addr;
	input wire logic [7:0] reg_wdata;
	input wire logic reg_wr;
	input wire logic reg_rd;
	output logic [15:0] reg_rdata;
	input wire logic [47:0] native_max;
	output drc_pkg::drc_media_req_type media_req;
	input wire drc_pkg::drc_media_rsp_type media_rsp;
	output logic busy;

	drc_state_type state_q, state_d;
	drc_addr_type tf_q, tf_d;
	drc_addr_type last_tf_q, last_tf_d;
	logic [7:0] count_q, count_d;
	logic [7:0] err_q, err_d;
	logic [7:0] stat_q, stat_d;
	logic lba_mode_q, lba_mode_d;
	logic hob_q, hob_d;
	logic [47:0] result_q, result_d;
	logic result_sel_q, result_sel_d;
	logic [8:0] remain_q, remain_d;
	logic [8:0] words_q, words_d;
	logic [15:0] word_q, word_d;
	logic word_full_q, word_full_d;
	logic [15:0] rdata_q, rdata_d;
	logic [27:0] cur_lba;
	logic [47:0] rd_addr;
	logic [7:0] sel_sector, sel_cyl_lo, sel_cyl_hi;
	logic data_rd;

	assign cur_lba = {tf_q.head, tf_q.cyl_hi, tf_q.cyl_lo, tf_q.sector};
	assign data_rd = reg_rd && reg_addr == `DRC_OFF_DATA;
	// native max result sits apart so a later read cannot disturb it
	assign rd_addr = result_sel_q ? result_q
		: {20'h00000, cur_lba};

	// three byte lanes share one selector module
	drc_byte_sel u_sel_sector (
		.addr(rd_addr),
		.high_byte_select(hob_q),
		.lane(2'h0),
		.byte_out(sel_sector)
	);
	drc_byte_sel u_sel_cyl_lo (
		.addr(rd_addr),
		.high_byte_select(hob_q),
		.lane(2'h1),
		.byte_out(sel_cyl_lo)
	);
	drc_byte_sel u_sel_cyl_hi (
		.addr(rd_addr),
		.high_byte_select(hob_q),
		.lane(2'h2),
		.byte_out(sel_cyl_hi)
	);

	// command sequencing, task file and media transfer
	always_comb begin
		state_d = state_q;
		tf_d = tf_q;
		last_tf_d = last_tf_q;
		count_d = count_q;
		err_d = err_q;
		stat_d = stat_q;
		lba_mode_d = lba_mode_q;
		hob_d = hob_q;
		result_d = result_q;
		result_sel_d = result_sel_q;
		remain_d = remain_q;
		words_d = words_q;
		word_d = word_q;
		word_full_d = word_full_q;
		media_req.req = 1'b0;
		media_req.lba = cur_lba;
		// host writes land only while idle; busy blocks writes but task file reads stay open
		if (reg_wr && !stat_q[`DRC_ST_BSY_BIT]) begin
			case (reg_addr)
			`DRC_OFF_COUNT: count_d = reg_wdata;
			`DRC_OFF_SECTOR: tf_d.sector = reg_wdata;
			`DRC_OFF_CYL_LO: tf_d.cyl_lo = reg_wdata;
			`DRC_OFF_CYL_HI: tf_d.cyl_hi = reg_wdata;
			`DRC_OFF_DEVHEAD: begin
				tf_d.head = reg_wdata[3:0];
				lba_mode_d = reg_wdata[`DRC_DH_LBA_BIT];
			end
			`DRC_OFF_CONTROL: hob_d = reg_wdata[`DRC_CTL_HOB_BIT];
			`DRC_OFF_COMMAND: begin
				err_d = 8'h00;
				stat_d[`DRC_ST_ERR_BIT] = 1'b0;
				result_sel_d = 1'b0;
				case (reg_wdata)
				`DRC_OP_NATIVE_MAX: begin
					// straight from the media size input, no limit applied
					result_d = native_max;
					result_sel_d = 1'b1;
				end
				`DRC_OP_READ_RETRY, `DRC_OP_READ_NORETRY: begin
					remain_d = (count_q == 8'h00)
						? `DRC_COUNT_ZERO_SECTORS
						: {1'b0, count_q};
					stat_d[`DRC_ST_BSY_BIT] = 1'b1;
					state_d = ST_FETCH;
					// first sector is the fallback report address
					last_tf_d = tf_q;
				end
				default: begin
					err_d[`DRC_ERR_ABT_BIT] = 1'b1;
					stat_d[`DRC_ST_ERR_BIT] = 1'b1;
				end
				endcase
			end
			default: ;
			endcase
		end
		case (state_q)
		ST_IDLE: ;
		ST_FETCH: begin
			// lba mode needs no translation; chs must stay inside geometry
			if (!lba_mode_q && ({8'h00, tf_q.sector} > SECTORS_PER_TRACK
					|| tf_q.head > HEADS || tf_q.sector == 8'h00)) begin
				err_d[`DRC_ERR_IDN_BIT] = 1'b1;
				state_d = ST_DONE;
			end else begin
				media_req.req = 1'b1;
				words_d = `DRC_WORDS_PER_SECTOR;
				state_d = ST_XFER;
			end
		end
		ST_XFER: begin
			if (word_full_q && data_rd) begin
				word_full_d = 1'b0;
				stat_d[`DRC_ST_DRQ_BIT] = 1'b0;
				if (words_q == 9'h001) begin
					remain_d = remain_q - 9'h001;
					count_d = 8'(remain_q - 9'h001);
					state_d = (remain_q == 9'h001) ? ST_DONE : ST_FETCH;
					// step the address past the sector just sent
					if (remain_q != 9'h001) begin
						last_tf_d = tf_q;
						if (lba_mode_q) begin
							{tf_d.head, tf_d.cyl_hi, tf_d.cyl_lo, tf_d.sector}
								= cur_lba + 28'h0000001;
						end else if ({8'h00, tf_q.sector}
								== SECTORS_PER_TRACK) begin
							tf_d.sector = 8'h01;
							if (tf_q.head == HEADS) begin
								tf_d.head = 4'h0;
								{tf_d.cyl_hi, tf_d.cyl_lo}
									= {tf_q.cyl_hi, tf_q.cyl_lo} + 16'h0001;
							end else begin
								tf_d.head = tf_q.head + 4'h1;
							end
						end else begin
							tf_d.sector = tf_q.sector + 8'h01;
						end
					end
				end
				words_d = words_q - 9'h001;
			end
			if (!word_full_q && media_rsp.valid) begin
				if (media_rsp.fail || media_rsp.not_found) begin
					// abandon the sector; count keeps what was left
					err_d[`DRC_ERR_UNC_BIT] = media_rsp.fail;
					err_d[`DRC_ERR_IDN_BIT] = media_rsp.not_found;
					count_d = 8'(remain_q);
					// task file falls back to the last sector sent
					tf_d = last_tf_q;
					state_d = ST_DONE;
				end else begin
					word_d = media_rsp.word;
					word_full_d = 1'b1;
					stat_d[`DRC_ST_DRQ_BIT] = 1'b1;
				end
			end
		end
		ST_DONE: begin
			stat_d[`DRC_ST_BSY_BIT] = 1'b0;
			stat_d[`DRC_ST_DRQ_BIT] = 1'b0;
			stat_d[`DRC_ST_ERR_BIT] = |err_q;
			word_full_d = 1'b0;
			state_d = ST_IDLE;
		end
		default: state_d = ST_IDLE;
		endcase
	end

	// register read mux, answer stands one cycle after the strobe
	always_comb begin
		rdata_d = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
			`DRC_OFF_DATA: rdata_d = word_q;
			`DRC_OFF_ERROR: rdata_d = {8'h00, err_q};
			`DRC_OFF_COUNT: rdata_d = {8'h00, count_q};
			`DRC_OFF_SECTOR: rdata_d = {8'h00, sel_sector};
			`DRC_OFF_CYL_LO: rdata_d = {8'h00, sel_cyl_lo};
			`DRC_OFF_CYL_HI: rdata_d = {8'h00, sel_cyl_hi};
			`DRC_OFF_DEVHEAD: begin
				rdata_d = {8'h00, 1'b1, lba_mode_q, 2'h2,
					result_sel_q ? result_q[27:24] : tf_q.head};
			end
			`DRC_OFF_STATUS: rdata_d = {8'h00, stat_q};
			`DRC_OFF_CONTROL: rdata_d = {8'h00, hob_q, 7'h00};
			default: rdata_d = 16'h0000;
			endcase
		end
	end

	// one register process for all state
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			tf_q <= '0;
			last_tf_q <= '0;
			count_q <= 8'h01;
			err_q <= 8'h00;
			stat_q <= 8'h50;
			lba_mode_q <= 1'b0;
			hob_q <= 1'b0;
			result_q <= 48'h000000000000;
			result_sel_q <= 1'b0;
			remain_q <= 9'h000;
			words_q <= 9'h000;
			word_q <= 16'h0000;
			word_full_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			tf_q <= tf_d;
			last_tf_q <= last_tf_d;
			count_q <= count_d;
			err_q <= err_d;
			stat_q <= stat_d;
			lba_mode_q <= lba_mode_d;
			hob_q <= hob_d;
			result_q <= result_d;
			result_sel_q <= result_sel_d;
			remain_q <= remain_d;
			words_q <= words_d;
			word_q <= word_d;
			word_full_q <= word_full_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign busy = stat_q[`DRC_ST_BSY_BIT];

	chk_native_max_load: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		reg_wr && reg_addr == `DRC_OFF_COMMAND && !busy
		&& reg_wdata == `DRC_OP_NATIVE_MAX
		|=> result_q == $past(native_max) && result_sel_q)
		else $error("native max not latched");
	chk_hob_select: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		reg_rd && reg_addr == `DRC_OFF_SECTOR && result_sel_q && hob_q
		|=> reg_rdata[7:0] == result_q[31:24])
		else $error("high byte select wrong");
	chk_read_start: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		reg_wr && reg_addr == `DRC_OFF_COMMAND && !busy
		&& reg_wdata[7:1] == 7'h10
		|=> busy && state_q == ST_FETCH)
		else $error("read opcode not taken");
	chk_zero_count: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		reg_wr && reg_addr == `DRC_OFF_COMMAND && !busy
		&& reg_wdata[7:1] == 7'h10 && count_q == 8'h00
		|=> remain_q == 9'h100)
		else $error("zero count not 256");
	chk_fetch_req: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		state_q == ST_FETCH |-> ##1 state_q inside {ST_XFER, ST_DONE})
		else $error("fetch stalled");
	chk_fail_stop: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		state_q == ST_XFER && !word_full_q && media_rsp.valid
		&& media_rsp.fail
		|=> state_q == ST_DONE ##1 !busy && stat_q[0] && err_q[6])
		else $error("error did not stop read");
	chk_drq_word: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		$rose(stat_q[`DRC_ST_DRQ_BIT]) |-> word_full_q)
		else $error("transfer flag without word");
	chk_done_count: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		$fell(busy) && !stat_q[`DRC_ST_ERR_BIT] |-> count_q == 8'h00)
		else $error("count not zero on success");

	// each finished sector leaves one fewer in the count
	chk_count_step: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		state_q == ST_XFER && word_full_q && data_rd
		&& words_q == 9'h001
		|=> count_q == $past(remain_q[7:0]) - 8'h01)
		else $error("count did not step");
	chk_last_addr_hold: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		state_q == ST_XFER && word_full_q && data_rd
		&& words_q == 9'h001 && remain_q == 9'h001
		|=> tf_q == $past(tf_q))
		else $error("last sector address moved");
	chk_lba_step: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		lba_mode_q && state_q == ST_XFER && word_full_q && data_rd
		&& words_q == 9'h001 && remain_q != 9'h001
		|=> cur_lba == $past(cur_lba) + 28'h0000001)
		else $error("address did not advance");
	chk_abort_flags: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		reg_wr && reg_addr == `DRC_OFF_COMMAND && !busy
		&& !(reg_wdata inside {`DRC_OP_NATIVE_MAX, `DRC_OP_READ_RETRY,
			`DRC_OP_READ_NORETRY})
		|=> err_q[`DRC_ERR_ABT_BIT] && stat_q[`DRC_ST_ERR_BIT])
		else $error("unknown opcode not aborted");
	chk_done_busy: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		state_q == ST_DONE |=> !busy)
		else $error("busy stuck after done");
endmodule : drc_exec

// file: bench/drc_media_model.sv
/*
 * media stand-in: answers each sector fetch with 256 words, one in flight.
 * assumes the bench pulses take when the host reads the data register.
 */
`timescale 1ns/1ps
module drc_media_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire drc_pkg::drc_media_req_type media_req,
	output drc_pkg::drc_media_rsp_type media_rsp,
	input wire logic take,
	input wire logic slow,
	input wire logic fail_en,
	input wire logic [27:0] fail_lba,
	output logic [15:0] req_count
);
	import drc_pkg::*;
	logic [27:0] lba_q;
	logic [7:0] idx_q;
	logic [2:0] wait_q;
	logic pend_q;
	// idle word lines toggle so a stale word never looks valid
	always @(posedge sys_clk) begin
		media_rsp.valid <= 1'b0;
		media_rsp.fail <= 1'b0;
		media_rsp.not_found <= 1'b0;
		media_rsp.word <= ~media_rsp.word;
		if (sys_rst) begin
			pend_q <= 1'b0;
			idx_q <= 8'h00;
			req_count <= 16'h0000;
			media_rsp.word <= 16'h5A5A;
		end else if (media_req.req) begin
			lba_q <= media_req.lba;
			idx_q <= 8'h00;
			wait_q <= {slow, 2'b01};
			pend_q <= 1'b1;
			req_count <= req_count + 16'h0001;
		end else if (take && idx_q != 8'hFF) begin
			idx_q <= idx_q + 8'h01;
			wait_q <= {slow, 2'b01};
			pend_q <= 1'b1;
		end else if (pend_q && wait_q != 3'h0) begin
			wait_q <= wait_q - 3'h1;
		end else if (pend_q) begin
			pend_q <= 1'b0;
			media_rsp.valid <= 1'b1;
			media_rsp.fail <= fail_en && lba_q == fail_lba;
			media_rsp.word <= {lba_q[7:0], idx_q};
		end
	end
endmodule : drc_media_model

// file: bench/tb_top.sv
/*
 * self-checking bench for drc_exec: host register traffic and media model.
 * assumes drc_pkg and the design files are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
	import drc_pkg::*;
	logic sys_clk, sys_rst, reg_wr, reg_rd, busy, slow, fail_en;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [15:0] reg_rdata, rv, req_count, r0;
	logic [47:0] native_max;
	logic [27:0] fail_lba, lba;
	logic [31:0] seed;
	drc_media_req_type media_req;
	drc_media_rsp_type media_rsp;
	int err_count, num_checks;

	drc_exec #(.SECTORS_PER_TRACK(16'h003F), .HEADS(4'hF)) uut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .native_max(native_max),
		.media_req(media_req), .media_rsp(media_rsp), .busy(busy));

	drc_media_model media (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .media_req(media_req),
		.media_rsp(media_rsp), .take(reg_rd && reg_addr == 4'h0),
		.slow(slow), .fail_en(fail_en), .fail_lba(fail_lba),
		.req_count(req_count));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// expected word: low address byte of the sector, then word index
	function automatic logic [15:0] exp_word(input logic [27:0] a,
			input int s, input int w);
		return {a[7:0] + s[7:0], w[7:0]};
	endfunction : exp_word

	task automatic nxt;
		repeat (32) seed = lfsr(seed);
	endtask : nxt

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		rv = reg_rdata;
	endtask : rd

	task automatic cmd(input logic [7:0] op, input logic [7:0] c,
			input logic [27:0] a, input logic [3:0] dh);
		wr(4'h2, c);
		wr(4'h3, a[7:0]);
		wr(4'h4, a[15:8]);
		wr(4'h5, a[23:16]);
		wr(4'h6, {dh, a[27:24]});
		wr(4'h7, op);
	endtask : cmd

	// poll status for the transfer request flag, then take each word
	task automatic xfer(input int n, input logic [27:0] a, input bit chk);
		int k;
		for (int s = 0; s < n; s++) begin
			for (int w = 0; w < 256; w++) begin
				k = 0;
				do begin
					rd(4'h7);
					k++;
				end while (rv[3] !== 1'b1 && k < 40);
				cmp(rv & 16'h0088, 16'h0088);
				rd(4'h0);
				if (chk)
					cmp(rv, exp_word(a, s, w));
			end
		end
	endtask : xfer

	task automatic wait_idle;
		int k;
		k = 0;
		do begin
			rd(4'h7);
			k++;
		end while (rv[7] !== 1'b0 && k < 60);
		cmp({15'h0000, busy}, 16'h0000);
	endtask : wait_idle

	// count, address bytes, head nibble, status, error
	task automatic res(input logic [7:0] c, input logic [27:0] a,
			input logic [7:0] st, input logic [7:0] e);
		logic [7:0] x [7];
		x = '{c, a[7:0], a[15:8], a[23:16], {4'h0, a[27:24]}, st, e};
		for (int i = 0; i < 7; i++) begin
			rd(i == 6 ? 4'h1 : 4'(i + 2));
			cmp(i == 4 ? {12'h000, rv[3:0]} : rv, {8'h00, x[i]});
		end
	endtask : res

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// about 25k cycles expected; a hang is cut well after that
	initial begin
		repeat (60000) @(posedge sys_clk);
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		end_sim;
	end

	initial begin
		{reg_wr, reg_rd, slow, fail_en} = 4'h0;
		{reg_addr, reg_wdata, fail_lba} = '0;
		sys_rst = 1'b1;
		seed = 32'h0618;
		nxt;
		native_max[47:32] = seed[15:0];
		nxt;
		native_max[31:0] = seed;
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		res(8'h01, 28'h0, 8'h50, 8'h00);
		rd(4'hF);
		cmp(rv, 16'h0000);
		$display("test reset done");
		wr(4'h7, 8'h27);
		for (int b = 0; b < 2; b++) begin
			wr(4'h8, {b[0], 7'h00});
			for (int i = 0; i < 3; i++) begin
				rd(4'(i + 3));
				cmp(rv, {8'h00, native_max[b * 24 + i * 8 +: 8]});
			end
		end
		wr(4'h8, 8'h00);
		rd(4'h6);
		cmp({12'h000, rv[3:0]}, {12'h000, native_max[27:24]});
		$display("test native_max done");
		for (int op = 0; op < 2; op++) begin
			nxt;
			lba = seed[27:0];
			slow <= seed[31];
			cmd(8'h20 | op[7:0], 8'h02, lba, 4'hE);
			xfer(2, lba, 1'b1);
			wait_idle;
			res(8'h00, lba + 28'h1, 8'h50, 8'h00);
			$display("test read op %0d done", op);
		end
		nxt;
		lba = {4'h0, seed[23:0]};
		fail_lba <= lba + 28'h3;
		fail_en <= 1'b1;
		r0 = req_count;
		cmd(8'h20, 8'h00, lba, 4'hE);
		xfer(3, lba, 1'b1);
		wait_idle;
		cmp(req_count - r0, 16'h0004);
		res(8'hFD, lba + 28'h2, 8'h51, 8'h40);
		fail_en <= 1'b0;
		$display("test media failure done");
		nxt;
		lba = {4'h0, seed[15:0], 8'h3F};
		cmd(8'h21, 8'h02, lba, 4'hA);
		xfer(2, lba, 1'b0);
		wait_idle;
		res(8'h00, {4'h1, lba[23:8], 8'h01}, 8'h50, 8'h00);
		cmd(8'h20, 8'h01, 28'h0, 4'hA);
		wait_idle;
		rd(4'h1);
		cmp(rv, 16'h0010);
		wr(4'h7, 8'h55);
		rd(4'h7);
		cmp(rv, 16'h0051);
		rd(4'h1);
		cmp(rv, 16'h0004);
		$display("test chs and aborts done");
		end_sim;
	end
endmodule : tb_top
